// [design/sams_pkg.sv]
// shared constants and types for the serial status-two block
package sams_pkg;
  localparam int DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_BAUD_HI = 6'h00;
  localparam logic [5:0] IDX_BAUD_LO = 6'h01;
  localparam logic [5:0] IDX_CTRL_ONE = 6'h02;
  localparam logic [5:0] IDX_STATUS_TWO = 6'h03;
  localparam logic [5:0] IDX_BREAK_CMD = 6'h04;
  localparam logic [5:0] IDX_INT_STATUS = 6'h05;
  localparam logic [5:0] IDX_INT_CLEAR = 6'h06;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h07;
  // serial_status_two fields
  localparam int BIT_ALT_MAP = 7;
  localparam int BIT_TX_POL = 4;
  localparam int BIT_RX_POL = 3;
  localparam int BIT_LONG_BRK = 2;
  localparam int BIT_TX_DIR = 1;
  localparam int BIT_RX_ACT = 0;
  // control_register_one, alt_control_two and break command fields
  localparam int BIT_FRAME9 = 4;
  localparam int BIT_SINGLE_WIRE = 5;
  localparam int BIT_IR_EN = 0;
  localparam int BIT_BREAK_GO = 0;
  // reset values
  localparam logic [7:0] RST_BAUD_HI = 8'h00;
  localparam logic [7:0] RST_BAUD_LO = 8'h04;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [3:0] RST_INT = 4'h0;
  // bit timing in sample ticks; break and frame lengths in bits
  localparam logic [3:0] TICK_SAMPLE = 4'h8;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] IR_PULSE_FIRST = 4'h7;
  localparam logic [3:0] IR_PULSE_LAST = 4'h9;
  localparam logic [3:0] BRK_BITS_SHORT = 4'hA;
  localparam logic [3:0] BRK_BITS_LONG = 4'hD;
  localparam logic [3:0] FRAME_BITS_SHORT = 4'hA;
  localparam logic [3:0] FRAME_BITS_LONG = 4'hB;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_RX_START = 0;
  localparam int IRQ_IDLE = 1;
  localparam int IRQ_FRAME_ERR = 2;
  localparam int IRQ_BREAK_DONE = 3;
  typedef enum logic {RX_SEARCH, RX_FRAME} sams_rx_state_t;
  typedef enum logic {TX_IDLE, TX_BREAK} sams_tx_state_t;
endpackage

// [design/sams_rx_if.sv]
// signals between the register core and the receive front end
`timescale 1ns/1ns
interface sams_rx_if;
  logic sample_tick;
  logic rx_bit;
  logic frame9;
  logic receiver_active_flag;
  logic start_evt;
  logic idle_evt;
  logic frame_err_evt;
  modport front (input sample_tick, input rx_bit, input frame9, output receiver_active_flag,
    output start_evt, output idle_evt, output frame_err_evt);
  modport core (output sample_tick, output rx_bit, output frame9, input receiver_active_flag,
    input start_evt, input idle_evt, input frame_err_evt);
endinterface

// [design/sams_rx_front.sv]
// receive front end: start-bit search, frame check and idle detection
`timescale 1ns/1ns
module sams_rx_front
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  sams_rx_if.front rx
);
  import sams_pkg::*;

  sams_rx_state_t rx_state;
  logic [3:0] tick_cnt;
  logic [3:0] bit_cnt;
  logic [7:0] ones_cnt;
  logic [3:0] frame_len;
  logic [7:0] idle_ticks;
  logic idle_hit;
  logic stop_sample;

  assign frame_len = rx.frame9 ? FRAME_BITS_LONG : FRAME_BITS_SHORT;
  assign idle_ticks = {frame_len, 4'h0};
  assign idle_hit = rx.rx_bit && (ones_cnt == idle_ticks - 8'h01);
  assign stop_sample = (tick_cnt == TICK_SAMPLE) && (bit_cnt == frame_len - 4'h1);

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_state <= RX_SEARCH;
      tick_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      ones_cnt <= 8'h00;
      rx.receiver_active_flag <= 1'b0;
      rx.start_evt <= 1'b0;
      rx.idle_evt <= 1'b0;
      rx.frame_err_evt <= 1'b0;
    end
    else
    begin
      rx.start_evt <= 1'b0;
      rx.idle_evt <= 1'b0;
      rx.frame_err_evt <= 1'b0;
      if (rx.sample_tick)
      begin
        // saturate so a long idle line never wraps into a false count
        ones_cnt <= !rx.rx_bit ? 8'h00 : (ones_cnt == 8'hFF) ? ones_cnt : ones_cnt + 8'h01;
        case (rx_state)
          RX_SEARCH:
          begin
            // [RULE10] set on first low tick
            if (!rx.rx_bit)
            begin
              rx_state <= RX_FRAME;
              tick_cnt <= 4'h1;
              bit_cnt <= 4'h0;
              rx.receiver_active_flag <= 1'b1;
              rx.start_evt <= 1'b1;
            end
            // [RULE11] clear on idle character
            else if (rx.receiver_active_flag && idle_hit)
            begin
              rx.receiver_active_flag <= 1'b0;
              rx.idle_evt <= 1'b1;
            end
          end
          RX_FRAME:
          begin
            tick_cnt <= tick_cnt + 4'h1;
            // [RULE7] stop check ignores break length
            if (stop_sample)
            begin
              rx_state <= RX_SEARCH;
              rx.frame_err_evt <= !rx.rx_bit;
            end
            else if (tick_cnt == TICK_SAMPLE)
            begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          default:
          begin
            rx_state <= RX_SEARCH;
          end
        endcase
      end
    end
  end

  sequence low_at_search;
    rx.sample_tick && rx_state == RX_SEARCH && !rx.rx_bit;
  endsequence

  start_sets_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE10]
    low_at_search |=> rx.receiver_active_flag && rx.start_evt && rx_state == RX_FRAME)
    else $error("active flag not set on start low");
  idle_clears_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE11]
    rx.idle_evt |-> !rx.receiver_active_flag && $past(rx.receiver_active_flag) && $past(ones_cnt) != 8'h00)
    else $error("idle event without clearing active flag");
  frame_err_cause_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE7]
    rx.frame_err_evt |-> $past(!rx.rx_bit) && $past(stop_sample) && $past(rx.sample_tick))
    else $error("framing error without low stop sample");
endmodule

// [design/sams_top.sv]
// serial status-two block: alternate map, polarity, break length, pin direction, active flag
// Summary of operation
// [RULE1] With the alternate map clear, indices 0,1,2 answer as baud high, baud low and control one.
// [RULE2] With the alternate map set, the same indices answer as alt status one, alt control one and two.
// [RULE3] The alternate map bit is clear after reset so the map matches older versions.
// [RULE4] The transmit polarity bit inverts transmitted NRZ levels and infrared pulse sense.
// [RULE5] The receive polarity bit applies the same inversion to received NRZ and infrared data.
// [RULE6] The long break bit makes a sent break 13 or 14 bits instead of 10 or 11, per frame length.
// [RULE7] Framing error detection in the receiver does not depend on the long break bit.
// [RULE8] In single-wire mode the transmit direction bit makes the transmit pin an input or output.
// [RULE9] Outside single-wire mode the transmit direction bit has no effect on the pin.
// [RULE10] The receiver active flag is set when the first sample tick of start search sees a zero.
// [RULE11] The receiver active flag is cleared when an idle character is detected.
// [RULE12] The receiver active flag is read-only; writes to its position are ignored.
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
module sams_top
#(
  parameter int ADR_W = 8,
  parameter int BAUD_W = 13
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [sams_pkg::DATA_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [sams_pkg::DATA_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_rx_line,
  input wire logic i_tx_line_in,
  output logic o_tx_line_out,
  output logic o_tx_line_oe_b,
  output logic o_irq
);
  import sams_pkg::*;

  sams_rx_if rx_bus();

  logic [7:0] baud_divider_high;
  logic [7:0] baud_divider_low;
  logic [7:0] control_register_one;
  logic [7:0] alt_control_one;
  logic [7:0] alt_control_two;
  logic alt_map_select;
  logic tx_polarity_invert;
  logic rx_polarity_invert;
  logic long_break_select;
  logic single_wire_tx_direction;
  logic [IRQ_W-1:0] int_status;
  logic [IRQ_W-1:0] int_enable;
  logic [BAUD_W-1:0] baud_cnt;
  logic sample_tick;
  sams_tx_state_t tx_state;
  logic [3:0] tx_tick;
  logic [3:0] tx_bits;
  logic [3:0] brk_len_q;
  logic break_done;
  logic [7:0] brk_ticks;
  logic first_done;

  // bus decode
  logic [5:0] idx;
  logic bus_req;
  logic wr_lo;
  logic rd;
  logic mapped;
  assign idx = i_wb_adr[7:2];
  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_lo = bus_req && i_wb_we && i_wb_sel[0];
  assign rd = bus_req && !i_wb_we;
  assign mapped = (i_wb_adr[ADR_W-1:2] <= (ADR_W-2)'(IDX_INT_ENABLE)) && (i_wb_adr[1:0] == 2'h0);

  // [RULE1] normal map writes
  logic wr_baud_hi;
  logic wr_baud_lo;
  logic wr_ctrl_one;
  assign wr_baud_hi = wr_lo && mapped && idx == IDX_BAUD_HI && !alt_map_select;
  assign wr_baud_lo = wr_lo && mapped && idx == IDX_BAUD_LO && !alt_map_select;
  assign wr_ctrl_one = wr_lo && mapped && idx == IDX_CTRL_ONE && !alt_map_select;
  // [RULE2] alternate map writes
  logic wr_alt_one;
  logic wr_alt_two;
  assign wr_alt_one = wr_lo && mapped && idx == IDX_BAUD_LO && alt_map_select;
  assign wr_alt_two = wr_lo && mapped && idx == IDX_CTRL_ONE && alt_map_select;
  logic wr_status_two;
  logic wr_break;
  logic wr_int_clear;
  logic wr_int_enable;
  assign wr_status_two = wr_lo && mapped && idx == IDX_STATUS_TWO;
  assign wr_break = wr_lo && mapped && idx == IDX_BREAK_CMD && i_wb_dat[BIT_BREAK_GO];
  assign wr_int_clear = wr_lo && mapped && idx == IDX_INT_CLEAR;
  assign wr_int_enable = wr_lo && mapped && idx == IDX_INT_ENABLE;

  logic frame9;
  logic single_wire;
  logic ir_en;
  logic in_break;
  assign frame9 = control_register_one[BIT_FRAME9];
  assign single_wire = control_register_one[BIT_SINGLE_WIRE];
  assign ir_en = alt_control_two[BIT_IR_EN];
  assign in_break = tx_state == TX_BREAK;

  // read data; alt status one shows received bit after polarity and infrared inversion, break and active state
  logic [7:0] status_two_rd;
  logic [7:0] alt_status_one;
  logic [7:0] rd_byte;
  assign status_two_rd = {alt_map_select, 2'b00, tx_polarity_invert, rx_polarity_invert,
    long_break_select, single_wire_tx_direction, rx_bus.receiver_active_flag};
  assign alt_status_one = {5'h00, rx_bus.rx_bit, in_break, rx_bus.receiver_active_flag};
  assign rd_byte = !mapped ? 8'h00 :
    (idx == IDX_BAUD_HI) ? (alt_map_select ? alt_status_one : baud_divider_high) :
    (idx == IDX_BAUD_LO) ? (alt_map_select ? alt_control_one : baud_divider_low) :
    (idx == IDX_CTRL_ONE) ? (alt_map_select ? alt_control_two : control_register_one) :
    (idx == IDX_STATUS_TWO) ? status_two_rd :
    (idx == IDX_INT_STATUS) ? {4'h0, int_status} :
    (idx == IDX_INT_ENABLE) ? {4'h0, int_enable} : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end
    else
    begin
      o_wb_ack <= bus_req;
      o_wb_dat <= rd ? {24'h000000, rd_byte} : '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      baud_divider_high <= RST_BAUD_HI;
      baud_divider_low <= RST_BAUD_LO;
      control_register_one <= RST_CTRL;
      alt_control_one <= RST_CTRL;
      alt_control_two <= RST_CTRL;
      int_enable <= RST_INT;
    end
    else
    begin
      if (wr_baud_hi) baud_divider_high <= i_wb_dat[7:0];
      if (wr_baud_lo) baud_divider_low <= i_wb_dat[7:0];
      if (wr_ctrl_one) control_register_one <= i_wb_dat[7:0];
      if (wr_alt_one) alt_control_one <= i_wb_dat[7:0];
      if (wr_alt_two) alt_control_two <= i_wb_dat[7:0];
      if (wr_int_enable) int_enable <= i_wb_dat[IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      // [RULE3] map starts in compatible layout
      alt_map_select <= 1'b0;
      tx_polarity_invert <= 1'b0;
      rx_polarity_invert <= 1'b0;
      long_break_select <= 1'b0;
      single_wire_tx_direction <= 1'b0;
    end
    // [RULE12] active flag bit not stored from bus
    else if (wr_status_two)
    begin
      alt_map_select <= i_wb_dat[BIT_ALT_MAP];
      tx_polarity_invert <= i_wb_dat[BIT_TX_POL];
      rx_polarity_invert <= i_wb_dat[BIT_RX_POL];
      long_break_select <= i_wb_dat[BIT_LONG_BRK];
      single_wire_tx_direction <= i_wb_dat[BIT_TX_DIR];
    end
  end

  // sample tick at 16 per bit; divider of zero stops the clock of the link logic
  logic [BAUD_W-1:0] divisor;
  assign divisor = {baud_divider_high[BAUD_W-9:0], baud_divider_low};
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      baud_cnt <= '0;
      sample_tick <= 1'b0;
    end
    else
    begin
      sample_tick <= (divisor != '0) && (baud_cnt >= divisor - 1'b1);
      baud_cnt <= ((divisor == '0) || (baud_cnt >= divisor - 1'b1)) ? '0 : baud_cnt + 1'b1;
    end
  end

  // [RULE6] break length from long break and frame size
  logic [3:0] brk_len;
  assign brk_len = (long_break_select ? BRK_BITS_LONG : BRK_BITS_SHORT) + {3'b000, frame9};
  assign break_done = in_break && sample_tick && tx_tick == TICK_LAST && tx_bits == brk_len_q - 4'h1;
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_state <= TX_IDLE;
      tx_tick <= 4'h0;
      tx_bits <= 4'h0;
      brk_len_q <= BRK_BITS_SHORT;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          tx_tick <= 4'h0;
          tx_bits <= 4'h0;
          // a break request while one runs is dropped
          if (wr_break)
          begin
            tx_state <= TX_BREAK;
            brk_len_q <= brk_len;
          end
        end
        TX_BREAK:
        begin
          if (sample_tick)
          begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == TICK_LAST) tx_bits <= tx_bits + 4'h1;
          end
          if (break_done) tx_state <= TX_IDLE;
        end
        default:
        begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // [RULE4] transmit polarity for NRZ and infrared
  logic tx_bit;
  logic ir_window;
  logic next_tx;
  assign tx_bit = !in_break;
  assign ir_window = tx_tick >= IR_PULSE_FIRST && tx_tick <= IR_PULSE_LAST;
  assign next_tx = (ir_en ? (!tx_bit && ir_window) : tx_bit) ^ tx_polarity_invert;

  // [RULE8] direction bit matters only in single-wire mode
  logic next_oe_b;
  assign next_oe_b = single_wire ? !single_wire_tx_direction : 1'b0;

  // [RULE5] receive polarity for NRZ and infrared
  logic rx_src;
  logic rx_nrz;
  assign rx_src = single_wire ? i_tx_line_in : i_rx_line;
  assign rx_nrz = rx_src ^ rx_polarity_invert;
  assign rx_bus.rx_bit = ir_en ? !rx_nrz : rx_nrz;
  assign rx_bus.sample_tick = sample_tick;
  assign rx_bus.frame9 = frame9;

  sams_rx_front u_rx_front
  (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .rx(rx_bus.front)
  );

  // sticky events; a set in the clear cycle wins
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr_mask;
  assign events = {break_done, rx_bus.frame_err_evt, rx_bus.idle_evt, rx_bus.start_evt};
  assign clr_mask = wr_int_clear ? i_wb_dat[IRQ_W-1:0] : '0;
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      int_status <= RST_INT;
      o_irq <= 1'b0;
      o_tx_line_out <= 1'b1;
      o_tx_line_oe_b <= 1'b0;
    end
    else
    begin
      int_status <= (int_status & ~clr_mask) | events;
      o_irq <= |(int_status & int_enable);
      o_tx_line_out <= next_tx;
      // [RULE9] pin stays driven outside single-wire mode
      o_tx_line_oe_b <= next_oe_b;
    end
  end

  // helper state read only by assertions
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      brk_ticks <= 8'h00;
      first_done <= 1'b0;
    end
    else
    begin
      first_done <= 1'b1;
      if (!in_break) brk_ticks <= 8'h00;
      else if (sample_tick) brk_ticks <= brk_ticks + 8'h01;
    end
  end

  sequence nrz_steady(logic pol, logic brk);
    (!ir_en && in_break == brk && tx_polarity_invert == pol) [*2];
  endsequence
  sequence sw_steady(logic dir);
    (single_wire && single_wire_tx_direction == dir) [*2];
  endsequence

  normal_map_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE1]
    rd && mapped && idx == IDX_BAUD_HI && !alt_map_select |=> o_wb_dat[7:0] == $past(baud_divider_high))
    else $error("normal map read wrong");
  alt_map_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE2]
    rd && mapped && idx == IDX_CTRL_ONE && alt_map_select |=> o_wb_dat[7:0] == $past(alt_control_two))
    else $error("alternate map read wrong");
  alt_hides_baud_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE2]
    wr_lo && idx == IDX_BAUD_HI && alt_map_select |=> $stable(baud_divider_high))
    else $error("hidden baud register written");
  reset_map_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE3]
    !first_done |-> !alt_map_select)
    else $error("alternate map set after reset");
  tx_pol_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE4]
    nrz_steady(1'b1, 1'b0) |-> !o_tx_line_out)
    else $error("inverted idle not low");
  tx_pol_break_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE4]
    nrz_steady(1'b0, 1'b1) |-> !o_tx_line_out)
    else $error("normal break not low");
  rx_pol_nrz_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE5]
    !ir_en && !single_wire |-> rx_bus.rx_bit == (i_rx_line ^ rx_polarity_invert))
    else $error("receive polarity wrong");
  break_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE6]
    break_done |-> brk_ticks + 8'h01 == {brk_len_q, 4'h0})
    else $error("break length wrong");
  sw_input_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE8]
    sw_steady(1'b0) |-> o_tx_line_oe_b)
    else $error("single-wire pin not released");
  sw_output_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE8]
    sw_steady(1'b1) |-> !o_tx_line_oe_b)
    else $error("single-wire pin not driven");
  dir_ignored_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE9]
    !single_wire [*2] |-> !o_tx_line_oe_b)
    else $error("pin released outside single-wire");
  flag_read_only_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RULE12]
    wr_status_two && !sample_tick |=> $stable(rx_bus.receiver_active_flag))
    else $error("active flag changed by write");
endmodule

// [bench/sams_line_model.sv]
// remote serial transceiver that drives the receive line
`timescale 1ns/1ns
module sams_line_model
#(
  parameter int BIT_CLKS = 32
)
(
  input wire logic i_ref_clk,
  input wire logic i_pol,
  output logic o_line
);
  logic bit_val = 1'b1;
  assign o_line = bit_val ^ i_pol;
  // one 10-bit frame, lsb first; gap idle bits first lets the far side answer slowly
  task automatic send(input logic [7:0] d, input logic stop, input int gap);
    logic [9:0] fr;
    fr = {stop, d, 1'b0};
    repeat (gap * BIT_CLKS) @(posedge i_ref_clk);
    for (int i = 0; i < 10; i++)
    begin
      bit_val <= fr[i];
      repeat (BIT_CLKS) @(posedge i_ref_clk);
    end
    bit_val <= 1'b1;
  endtask
endmodule

// [bench/tb.sv]
// self-checking bench for the serial status-two block
`timescale 1ns/1ns
module tb;
  import sams_pkg::*;
  localparam int DIV = 2;
  localparam int BITC = 16 * DIV;
  localparam int BRK_DIV = 1;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic ack, tx_out, tx_oe_b, irq, peer_line, tx_wire;
  logic peer_pol = 1'b0;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 32'h228b3b92;
  always #5 ref_clk = ~ref_clk;
  // the pin level follows whoever drives it in single-wire mode
  assign tx_wire = tx_oe_b ? peer_line : tx_out;
  sams_top u_dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_rx_line(peer_line), .i_tx_line_in(tx_wire), .o_tx_line_out(tx_out), .o_tx_line_oe_b(tx_oe_b),
    .o_irq(irq));
  sams_line_model #(.BIT_CLKS(BITC)) u_peer (.i_ref_clk(ref_clk), .i_pol(peer_pol), .o_line(peer_line));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] r);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    sel <= 4'h1;
    // no cycle budget here: only the bench timeout ends a wait
    @(posedge ref_clk);
    while (ack !== 1'b1)
      @(posedge ref_clk);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, idx, d, r);
  endtask
  task automatic rd(input string name, input logic [5:0] idx, input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, idx, 8'h00, r);
    chk(name, {24'h000000, r}, {24'h000000, e});
  endtask
  // long enough for a stray frame plus a full idle character to pass
  task automatic settle();
    repeat (24 * BITC) @(posedge ref_clk);
    wr(IDX_INT_CLEAR, 8'h0F);
  endtask
  function automatic int brk_exp(input logic l, input logic f9, input logic ir);
    int len;
    len = (l ? 13 : 10) + int'(f9);
    return (ir ? 3 * len : 16 * len) * BRK_DIV;
  endfunction
  function automatic logic oe_exp(input logic sw, input logic dir);
    return sw ? ~dir : 1'b0;
  endfunction
  task automatic end_sim();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    logic [7:0] v;
    logic [7:0] q;
    logic idle;
    int c;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd("baud_hi", IDX_BAUD_HI, RST_BAUD_HI);
    rd("baud_lo", IDX_BAUD_LO, RST_BAUD_LO);
    rd("ctrl_one", IDX_CTRL_ONE, RST_CTRL);
    rd("status_two", IDX_STATUS_TWO, 8'h00);
    rd("int_status", IDX_INT_STATUS, 8'h00);
    wr(IDX_BAUD_LO, 8'(DIV));
    wr(IDX_STATUS_TWO, 8'h80);
    rd("alt_status_one", IDX_BAUD_HI, 8'h04);
    v = 8'($random(seed));
    wr(IDX_BAUD_LO, v);
    // alt status one is read-only, so the hidden baud high must keep its value
    wr(IDX_BAUD_HI, v);
    rd("alt_control_one", IDX_BAUD_LO, v);
    rd("alt_control_two", IDX_CTRL_ONE, 8'h00);
    wr(IDX_STATUS_TWO, 8'h00);
    rd("baud_lo_hidden", IDX_BAUD_LO, 8'(DIV));
    rd("baud_hi_hidden", IDX_BAUD_HI, RST_BAUD_HI);
    rd("unmapped", 6'h10, 8'h00);
    rd("int_clear", IDX_INT_CLEAR, 8'h00);
    v = 8'($random(seed));
    wr(IDX_INT_ENABLE, {4'h0, v[3:0]});
    rd("int_enable", IDX_INT_ENABLE, {4'h0, v[3:0]});
    wr(IDX_INT_ENABLE, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      peer_pol <= p[0];
      // bit 0 of this write must not stick
      wr(IDX_STATUS_TWO, {4'h0, p[0], 3'b001});
      settle();
      rd("active_idle", IDX_STATUS_TWO, {4'h0, p[0], 3'b000});
      fork
        u_peer.send(8'($random(seed)), 1'b1, p);
      join_none
      repeat ((p + 3) * BITC) @(posedge ref_clk);
      rd("active_set", IDX_STATUS_TWO, {4'h0, p[0], 3'b001});
      repeat (20 * BITC) @(posedge ref_clk);
      rd("active_clear", IDX_STATUS_TWO, {4'h0, p[0], 3'b000});
      rd("rx_events", IDX_INT_STATUS, 8'h03);
      chk("irq_masked", irq, 1'b0);
      wr(IDX_INT_ENABLE, 8'h02);
      repeat (2) @(posedge ref_clk);
      chk("irq_on", irq, 1'b1);
      wr(IDX_INT_CLEAR, 8'h02);
      repeat (2) @(posedge ref_clk);
      chk("irq_off", irq, 1'b0);
      rd("after_clear", IDX_INT_STATUS, 8'h01);
      wr(IDX_INT_ENABLE, 8'h00);
    end
    peer_pol <= 1'b0;
    for (int l = 0; l < 2; l++)
    begin
      wr(IDX_STATUS_TWO, {5'h00, l[0], 2'b00});
      settle();
      u_peer.send(8'($random(seed)), 1'b0, 0);
      repeat (2 * BITC) @(posedge ref_clk);
      rd("frame_err", IDX_INT_STATUS, 8'h05);
    end
    // one tick per clock makes break lengths exact in clock cycles
    wr(IDX_BAUD_LO, 8'(BRK_DIV));
    for (int ir = 0; ir < 2; ir++)
    begin
      wr(IDX_STATUS_TWO, 8'h80);
      wr(IDX_CTRL_ONE, 8'(ir));
      wr(IDX_STATUS_TWO, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
        wr(IDX_CTRL_ONE, {3'b000, k[1], 4'h0});
        wr(IDX_STATUS_TWO, {3'b000, k[0], 1'b0, k[2], 2'b00});
        idle = ir[0] ? k[0] : ~k[0];
        repeat (4) @(posedge ref_clk);
        chk("tx_idle", tx_out, idle);
        c = 0;
        wr(IDX_BREAK_CMD, 8'h01);
        // a second command lands mid-break and must not stretch it
        fork
          for (int i = 0; i < 17 * BITC; i++)
          begin
            @(posedge ref_clk);
            if (tx_out !== idle)
              c++;
          end
          wr(IDX_BREAK_CMD, 8'h01);
        join
        chk("break_len", c, brk_exp(k[2], k[1], ir[0]));
        wb(1'b0, IDX_INT_STATUS, 8'h00, q);
        chk("break_done", {24'h000000, q & 8'h08}, 32'h00000008);
        wr(IDX_INT_CLEAR, 8'h0F);
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_CTRL_ONE, {2'b00, k[1], 5'h00});
      wr(IDX_STATUS_TWO, {6'h00, k[0], 1'b0});
      repeat (3) @(posedge ref_clk);
      chk("tx_oe_b", tx_oe_b, oe_exp(k[1], k[0]));
    end
    end_sim();
  end
endmodule
